//--- core/pse_pkg.sv
package pse_pkg;

  // Phase count limits
  localparam int          MAX_PHASES        = 6;
  localparam int          PH_W              = 3;

  // Power state codes as carried by the power-state command
  localparam logic [7:0]  PS_FULL           = 8'h00;
  localparam logic [7:0]  PS_LIGHT          = 8'h01;

  // Current indicator / limit code width (unsigned ADC counts)
  localparam int          CUR_W             = 10;

  // Clock and timing
  localparam int          CLK_HZ            = 10_000_000;
  localparam int          MIN_DE_FREQ_HZ    = 30_000;
  // Longest firing period in diode emulation, rounded down
  localparam int          DE_MAX_PERIOD_CYC = CLK_HZ / MIN_DE_FREQ_HZ;
  // Re-arm delay for shedding after a reset, in microseconds
  localparam int          REARM_US          = 100;
  localparam int          REARM_CYC         = REARM_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W             = 12;

  // Values after reset
  localparam logic [PH_W-1:0] RST_PHASES    = 3'h6;

  // Command strobes from the serial power-state master
  typedef struct packed {
    logic       set_ps;      // Power-state command strobe
    logic [7:0] ps_code;     // Commanded state
    logic       set_vid_core;// Voltage-set command for core section
  } ps_cmd_s;

  // Analog measurement codes
  typedef struct packed {
    logic [CUR_W-1:0] load_ind;   // Filtered load-current indicator
    logic [CUR_W-1:0] fast_lim;   // Lightly filtered fast current limit
    logic [CUR_W-1:0] ocp_ref;    // Overcurrent reference (2.5 V full scale)
    logic [CUR_W-1:0] gd_thr;     // Automatic gate-drive threshold
  } meas_s;

endpackage : pse_pkg

//--- core/de_phase_timer.sv
`timescale 1ns/1ps
// One diode-emulation phase sequencer: high side, low side, then idle
module de_phase_timer
  import pse_pkg::*;
#(
  parameter int TIME_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Control
  input  wire logic              de_en,       // Diode emulation active
  input  wire logic              fire,        // Normal switching request
  input  wire logic [TIME_W-1:0] on_time,
  input  wire logic [TIME_W-1:0] off_time,
  input  wire logic              zero_crossing_detect,
  // Drive
  output logic                   hs_on,
  output logic                   ls_on,
  output logic                   hiz,
  output logic                   cycle_end    // Switching-cycle boundary
);

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} dst_e;

  typedef struct packed {
    dst_e             st;
    logic [TIME_W-1:0] t;
    logic [CNT_W-1:0]  idle;  // Cycles since last firing, saturating
  } dstate_s;

  dstate_s q_r, q_nxt;

  // Next-state: on-time, off-time, then idle until fire; idle is high impedance only in emulation
  always_comb begin
    q_nxt = q_r;
    // Count the whole period, on and off time included, from last firing
    if (q_r.idle != CNT_W'(DE_MAX_PERIOD_CYC)) begin
      q_nxt.idle = q_r.idle + 1'b1;
    end
    unique case (q_r.st)
      ST_IDLE: begin
        // Fire on request, or forced so frequency stays above floor
        if (fire || (de_en && q_r.idle >= CNT_W'(DE_MAX_PERIOD_CYC - 1))) begin
          q_nxt.st   = ST_HIGH;
          q_nxt.t    = on_time;
          q_nxt.idle = '0;
        end
      end
      ST_HIGH: begin
        if (q_r.t <= 1) begin
          q_nxt.st = ST_LOW;
          q_nxt.t  = off_time;
        end else begin
          q_nxt.t = q_r.t - 1'b1;
        end
      end
      ST_LOW: begin
        // In emulation the low side also ends when current crosses zero
        if (q_r.t <= 1 || (de_en && zero_crossing_detect)) begin
          q_nxt.st = ST_IDLE;
          q_nxt.t  = '0;
        end else begin
          q_nxt.t = q_r.t - 1'b1;
        end
      end
      default: q_nxt.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs decoded from state
  assign hs_on     = (q_r.st == ST_HIGH);
  assign ls_on     = (q_r.st == ST_LOW) || (q_r.st == ST_IDLE && !de_en);
  assign hiz       = (q_r.st == ST_IDLE) && de_en;
  assign cycle_end = (q_r.st == ST_LOW) && (q_nxt.st == ST_IDLE);

endmodule : de_phase_timer

//--- core/power_state_efficiency_control.sv
`timescale 1ns/1ps
// Overview of operation
// - Light state always sheds between one and two
// - Emulation gated by state, single phase, shedding
// - Shed phases by comparing indicator with thresholds
// - Threshold k separates k and k+1 phases
// - Evaluate only after ready; soft-start all phases
// - Core voltage command or transient resets shedding
// - Re-arm shedding after delay if indicator allows
// - Fast limit split into N steps of ref/2N
// - Raise phase count to fast limit step
// - Fast comparison only ever raises phase count
// - Multi section emulates only single phase, boundary
// - Single section always emulates near boundary
// - Zero-crossing from sense inputs marks boundary
// - High side, low side, then high impedance
// - Apparent frequency never below 30 kHz
// - Gate supply switches between five volt, driver
// - Default driver rail; five volt from light state
// - Automatic threshold enables switchover in full state
module power_state_efficiency_control
  import pse_pkg::*;
#(
  parameter int N_PHASES = MAX_PHASES,   // Populated phases
  parameter int TIME_W   = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Enable and regulator status
  input  wire logic                 enable,
  input  wire logic                 regulator_ready,
  // Power-state master commands
  input  wire ps_cmd_s              cmd,
  input  wire logic                 load_transient_detector,
  // Configuration from straps and management bus
  input  wire logic                 phase_shedding_en,
  input  wire logic                 auto_gd_en,
  input  wire logic [N_PHASES-2:0][CUR_W-1:0] shed_thr,  // shed_threshold_one_two first
  // Measurements
  input  wire meas_s                meas,
  input  wire logic                 zero_crossing_detect,   // Multi section, phase one
  input  wire logic                 single_zero_crossing,   // Single section
  // Switching timebase
  input  wire logic [N_PHASES-1:0]  fire,
  input  wire logic                 single_fire,
  input  wire logic [TIME_W-1:0]    on_time,
  input  wire logic [TIME_W-1:0]    off_time,
  // Status and drive outputs
  output logic [PH_W-1:0]           active_phases,
  output logic                      diode_emulation_mode,
  output logic                      single_diode_emulation,
  output logic                      gate_drive_supply_select, // 1: five_volt_rail
  output logic                      driver_enable_out,
  output logic                      single_section_driver_enable_out,
  output logic                      phase1_hs,
  output logic                      phase1_ls,
  output logic                      phase1_hiz
);

  localparam logic [PH_W-1:0] NPH = PH_W'(N_PHASES);

  // Whole module state
  typedef struct packed {
    logic [7:0]       ps;          // Current power state
    logic             armed;       // Shedding evaluating indicator
    logic [CNT_W-1:0] rearm_cnt;   // Delay after shedding reset
    logic [PH_W-1:0]  phases;      // Applied phase count
    logic             near_bnd;    // Multi section near boundary
    logic             s_near_bnd;  // Single section near boundary
    logic             de;          // Multi section emulating
    logic             sde;         // Single section emulating
    logic             gd5;         // Gate drive on five volt rail
  } state_s;

  state_s q_r, q_nxt;

  logic [PH_W-1:0]  shed_target;   // Count from filtered indicator
  logic [PH_W-1:0]  fast_target;   // Count from fast limit step
  logic [PH_W-1:0]  want;          // Requested count
  logic [CUR_W+3:0] step_acc;      // Running step edge
  logic             hs1;
  logic             ls1;
  logic             hiz1;
  logic             cyc_end1;
  logic             s_cyc_end;
  logic             light;
  logic             shed_active;

  assign light       = (q_r.ps >= PS_LIGHT);
  // Light state sheds regardless of strap
  assign shed_active = phase_shedding_en || light;

  // Phase count from filtered indicator and per-step thresholds
  always_comb begin
    shed_target = PH_W'(1);
    for (int k = 0; k < N_PHASES - 1; k++) begin
      // Threshold k moves between k+1 and k+2 phases
      if (meas.load_ind >= shed_thr[k]) begin
        shed_target = PH_W'(k + 2);
      end
    end
    // Light state limits to one or two phases
    if (q_r.ps >= PS_LIGHT && shed_target > PH_W'(2)) begin
      shed_target = PH_W'(2);
    end
  end

  // Fast limit step: width ocp_ref / (2N), steps counted from zero
  always_comb begin
    fast_target = PH_W'(1);
    step_acc    = '0;
    for (int k = 1; k < N_PHASES; k++) begin
      // Edge of step k is k * ref / (2N); compare scaled by 2N
      step_acc = (CUR_W+4)'(k) * (CUR_W+4)'(meas.ocp_ref);
      if ((CUR_W+4)'(meas.fast_lim) * (CUR_W+4)'(2 * N_PHASES) >= step_acc) begin
        fast_target = PH_W'(k + 1);
      end
    end
  end

  // Requested count: safety only raises above shedding choice
  always_comb begin
    if (!q_r.armed) begin
      want = NPH;
    end else if (fast_target > shed_target) begin
      want = fast_target;
    end else begin
      want = shed_target;
    end
  end

  // Next-state logic
  always_comb begin
    q_nxt = q_r;
    // Latch commanded power state
    if (cmd.set_ps) begin
      q_nxt.ps = cmd.ps_code;
    end
    // Arming of shedding evaluation
    if (!enable || !regulator_ready || !shed_active) begin
      q_nxt.armed     = 1'b0;
      q_nxt.rearm_cnt = '0;
    end else if (cmd.set_vid_core || load_transient_detector) begin
      q_nxt.armed     = 1'b0;
      q_nxt.rearm_cnt = CNT_W'(REARM_CYC);
    end else if (!q_r.armed) begin
      if (q_r.rearm_cnt != '0) begin
        q_nxt.rearm_cnt = q_r.rearm_cnt - 1'b1;
      end else if (shed_target < NPH) begin
        q_nxt.armed = 1'b1;
      end
    end
    // Apply count: raise at once, reduce only at cycle boundary
    if (!q_nxt.armed || want > q_r.phases) begin
      q_nxt.phases = q_nxt.armed ? want : NPH;
    end else if (want < q_r.phases && cyc_end1) begin
      q_nxt.phases = want;
    end
    // Boundary detection from zero-crossing of inductor current
    if (cyc_end1) begin
      q_nxt.near_bnd = zero_crossing_detect;
    end
    if (s_cyc_end) begin
      q_nxt.s_near_bnd = single_zero_crossing;
    end
    // Multi section emulation permission
    if (q_r.phases == PH_W'(1) && q_r.near_bnd && enable
        && (light || phase_shedding_en)) begin
      q_nxt.de = 1'b1;
    end else if (!q_r.near_bnd || q_r.phases != PH_W'(1) || !enable) begin
      q_nxt.de = 1'b0;
    end
    // Single section always emulates near boundary
    q_nxt.sde = enable && q_r.s_near_bnd;
    // Gate supply rail choice
    if (light) begin
      q_nxt.gd5 = 1'b1;
    end else if (auto_gd_en) begin
      q_nxt.gd5 = (meas.load_ind < meas.gd_thr);
    end else begin
      q_nxt.gd5 = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q_r        <= '0;
      q_r.phases <= RST_PHASES;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Phase one of the multi section
  de_phase_timer #(
    .TIME_W (TIME_W)
  ) u_phase1 (
    .clk                  (clk),
    .rstn                 (rstn),
    .de_en                (q_r.de),
    .fire                 (fire[0] && enable),
    .on_time              (on_time),
    .off_time             (off_time),
    .zero_crossing_detect (zero_crossing_detect),
    .hs_on                (hs1),
    .ls_on                (ls1),
    .hiz                  (hiz1),
    .cycle_end            (cyc_end1)
  );

  // Single section timer gives its cycle boundary
  de_phase_timer #(
    .TIME_W (TIME_W)
  ) u_single (
    .clk                  (clk),
    .rstn                 (rstn),
    .de_en                (q_r.sde),
    .fire                 (single_fire && enable),
    .on_time              (on_time),
    .off_time             (off_time),
    .zero_crossing_detect (single_zero_crossing),
    .hs_on                (),
    .ls_on                (),
    .hiz                  (),
    .cycle_end            (s_cyc_end)
  );

  // Outputs
  assign active_phases                    = q_r.phases;
  assign diode_emulation_mode             = q_r.de;
  assign single_diode_emulation           = q_r.sde;
  assign gate_drive_supply_select         = q_r.gd5;
  // Driver enable low requests diode mode of an integrated stage
  assign driver_enable_out                = enable && !q_r.de;
  assign single_section_driver_enable_out = enable && !q_r.sde;
  assign phase1_hs                        = hs1;
  assign phase1_ls                        = ls1;
  assign phase1_hiz                       = hiz1;

endmodule : power_state_efficiency_control

//--- dv/pse_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the efficiency control block
module pse_asserts
  import pse_pkg::*;
#(
  parameter int N_PHASES = MAX_PHASES
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rstn,
  // Watched inputs
  input wire logic            enable,
  input wire logic            regulator_ready,
  input wire ps_cmd_s         cmd,
  input wire logic            load_transient_detector,
  // Watched outputs
  input wire logic [PH_W-1:0] active_phases,
  input wire logic            diode_emulation_mode,
  input wire logic            gate_drive_supply_select,
  input wire logic            driver_enable_out,
  input wire logic            phase1_hs,
  input wire logic            phase1_ls,
  input wire logic            phase1_hiz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [9:0] idle_r; // Idle run while emulating
  // Counts idle cycles so a too-long gap is seen
  always_ff @(posedge clk) begin
    if (!rstn || !(diode_emulation_mode && phase1_hiz)) idle_r <= 10'h000;
    else if (idle_r != 10'h3ff) idle_r <= idle_r + 10'h001;
  end
  property p_shed_reset;
    load_transient_detector || cmd.set_vid_core |=> active_phases == PH_W'(N_PHASES);
  endproperty
  a_shed_reset: assert property (p_shed_reset) else $error("phases not restored");
  property p_ready;
    $past(active_phases) == PH_W'(N_PHASES) && active_phases < PH_W'(N_PHASES) |-> $past(regulator_ready);
  endproperty
  a_ready: assert property (p_ready) else $error("shed before ready");
  property p_range;
    active_phases >= 3'h1 && active_phases <= PH_W'(N_PHASES);
  endproperty
  a_range: assert property (p_range) else $error("phase count out of range");
  property p_de_single;
    $rose(diode_emulation_mode) |-> $past(active_phases) == 3'h1;
  endproperty
  a_de_single: assert property (p_de_single) else $error("emulation with several phases");
  property p_drv;
    driver_enable_out == (enable && !diode_emulation_mode);
  endproperty
  a_drv: assert property (p_drv) else $error("driver enable wrong");
  property p_hs_ls;
    $fell(phase1_hs) |-> phase1_ls && !phase1_hiz;
  endproperty
  a_hs_ls: assert property (p_hs_ls) else $error("low side not after high side");
  property p_excl;
    $onehot({phase1_hs, phase1_ls, phase1_hiz});
  endproperty
  a_excl: assert property (p_excl) else $error("phase drive not exclusive");
  property p_gd_light;
    cmd.set_ps && cmd.ps_code >= PS_LIGHT |-> ##[1:2] gate_drive_supply_select;
  endproperty
  a_gd_light: assert property (p_gd_light) else $error("no five volt in light state");
  property p_floor;
    idle_r <= 10'(DE_MAX_PERIOD_CYC + 8);
  endproperty
  a_floor: assert property (p_floor) else $error("emulation idle too long");
endmodule : pse_asserts
bind power_state_efficiency_control pse_asserts #(.N_PHASES(N_PHASES)) u_chk (.clk(clk), .rstn(rstn),
  .enable(enable), .regulator_ready(regulator_ready), .cmd(cmd), .load_transient_detector(load_transient_detector),
  .active_phases(active_phases), .diode_emulation_mode(diode_emulation_mode),
  .gate_drive_supply_select(gate_drive_supply_select), .driver_enable_out(driver_enable_out),
  .phase1_hs(phase1_hs), .phase1_ls(phase1_ls), .phase1_hiz(phase1_hiz));

//--- dv/ps_master_model.sv
`timescale 1ns/1ps
// Serial power-state master: one-cycle command strobes
module ps_master_model
  import pse_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Command strobes
  output ps_cmd_s   cmd
);
  initial cmd = '0;
  // Power-state command; code is scrambled once released
  task automatic send_ps(input logic [7:0] code);
    @(negedge clk);
    cmd.ps_code = code;
    cmd.set_ps  = 1'b1;
    @(negedge clk);
    cmd.set_ps  = 1'b0;
    cmd.ps_code = ~code;
  endtask : send_ps
  // Voltage-set strobe aimed at the core section
  task automatic send_vid_core;
    @(negedge clk);
    cmd.set_vid_core = 1'b1;
    @(negedge clk);
    cmd.set_vid_core = 1'b0;
  endtask : send_vid_core
endmodule : ps_master_model

//--- dv/power_state_efficiency_control_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the efficiency control block
module power_state_efficiency_control_tb_top
  import pse_pkg::*;
;
  `define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin $display("unexpected %s expected %0h seen %0h", nm, ex, got); fails++; end end
  logic            clk = 1'b0, rstn = 1'b0, enable = 1'b1, ready = 1'b0;  // Clock, reset, status
  logic            ltd = 1'b0, shed_en = 1'b0, auto_gd = 1'b0;            // Controls
  logic            fire_on = 1'b1, fire0 = 1'b0, zc_on = 1'b1;            // Timebase
  logic [CUR_W-1:0] fast = 10'h000, load = 10'h020;                        // Fast limit, load codes
  meas_s           meas;                                                   // Measurements
  ps_cmd_s         cmd;                                                    // Master commands
  int              tick = 0, fails = 0, total_checks = 0, n;
  logic [PH_W-1:0] ph;
  logic            de, sde, gds, drv, sdrv, hs, ls, hiz, zc;
  // Clock: 100 ns period
  always #50 clk = ~clk;
  // Switching timebase, zero crossing inside the off-time
  always @(negedge clk) begin
    tick  <= (tick == 39) ? 0 : tick + 1;
    fire0 <= fire_on && (tick == 0);
  end
  assign zc   = zc_on && (tick >= 8);
  assign meas = '{load_ind: load, fast_lim: fast, ocp_ref: 10'h3e8, gd_thr: 10'h200};
  ps_master_model master (.clk(clk), .cmd(cmd));
  power_state_efficiency_control dut (.clk(clk), .rstn(rstn), .enable(enable), .regulator_ready(ready),
    .cmd(cmd), .load_transient_detector(ltd), .phase_shedding_en(shed_en), .auto_gd_en(auto_gd),
    .shed_thr({10'h300, 10'h280, 10'h200, 10'h180, 10'h100}), .meas(meas), .zero_crossing_detect(zc),
    .single_zero_crossing(zc), .fire({5'h00, fire0}), .single_fire(fire0), .on_time(8'h04), .off_time(8'h06),
    .active_phases(ph), .diode_emulation_mode(de), .single_diode_emulation(sde),
    .gate_drive_supply_select(gds), .driver_enable_out(drv), .single_section_driver_enable_out(sdrv),
    .phase1_hs(hs), .phase1_ls(ls), .phase1_hiz(hiz));
  // Waits a bounded time for a phase count
  task automatic wait_ph(input logic [PH_W-1:0] want);
    for (int i = 0; i < 3000 && ph !== want; i++) @(negedge clk);
  endtask : wait_ph
  // Values right after reset
  task automatic t_reset;
    `CHK("active_phases", 3'h6, ph)
    `CHK("gate_drive", 1'b0, gds)
    `CHK("emulation", 1'b0, de)
    `CHK("driver_enable", 1'b1, drv)
    `CHK("single_emulation", 1'b0, sde)
    `CHK("single_driver_enable", 1'b1, sdrv)
    `CHK("phase1_ls", 1'b1, ls)
    $display("test reset done");
  endtask : t_reset
  // Full state: no shedding, no multi section emulation, single section emulates, automatic gate drive
  task automatic t_full;
    master.send_ps(PS_FULL);
    repeat (1500) @(negedge clk);
    `CHK("active_phases", 3'h6, ph)
    `CHK("emulation", 1'b0, de)
    `CHK("gate_drive", 1'b0, gds)
    `CHK("single_emulation", 1'b1, sde)
    `CHK("single_driver_enable", 1'b0, sdrv)
    auto_gd = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("gate_drive", 1'b1, gds)
    auto_gd = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("gate_drive", 1'b0, gds)
    $display("test full state done");
  endtask : t_full
  // Light state: one phase, emulation, frequency floor, fast override
  task automatic t_light;
    master.send_ps(PS_LIGHT);
    repeat (3) @(negedge clk);
    `CHK("gate_drive", 1'b1, gds)
    wait_ph(3'h1);
    `CHK("active_phases", 3'h1, ph)
    for (int i = 0; i < 200 && de !== 1'b1; i++) @(negedge clk);
    `CHK("emulation", 1'b1, de)
    `CHK("driver_enable", 1'b0, drv)
    fire_on = 1'b0;
    @(negedge clk iff hiz === 1'b1);
    for (n = 0; n < 400 && hs !== 1'b1; n++) @(negedge clk);
    `CHK("forced_fire", 1'b1, n <= DE_MAX_PERIOD_CYC + 20)
    fire_on = 1'b1;
    fast = 10'h064;
    for (int i = 0; i < 100 && ph !== 3'h2; i++) @(negedge clk);
    `CHK("active_phases", 3'h2, ph)
    repeat (3) @(negedge clk);
    `CHK("emulation", 1'b0, de)
    fast = 10'h000;
    wait_ph(3'h1);
    `CHK("active_phases", 3'h1, ph)
    for (int i = 0; i < 100 && de !== 1'b1; i++) @(negedge clk);
    `CHK("emulation", 1'b1, de)
    zc_on = 1'b0;
    for (int i = 0; i < 100 && (de !== 1'b0 || sde !== 1'b0); i++) @(negedge clk);
    `CHK("emulation", 1'b0, de)
    `CHK("single_emulation", 1'b0, sde)
    `CHK("single_driver_enable", 1'b1, sdrv)
    zc_on = 1'b1;
    $display("test light state done");
  endtask : t_light
  // Full state with shedding strapped on: ready gate, thresholds, emulation
  task automatic t_shed_full;
    ready   = 1'b0;
    shed_en = 1'b1;
    repeat (200) @(negedge clk);
    `CHK("active_phases", 3'h6, ph)
    ready = 1'b1;
    wait_ph(3'h1);
    `CHK("active_phases", 3'h1, ph)
    for (int i = 0; i < 200 && de !== 1'b1; i++) @(negedge clk);
    `CHK("emulation", 1'b1, de)
    load = 10'h180;
    repeat (3) @(negedge clk);
    `CHK("active_phases", 3'h3, ph)
    `CHK("emulation", 1'b0, de)
    load    = 10'h020;
    shed_en = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("active_phases", 3'h6, ph)
    `CHK("gate_drive", 1'b0, gds)
    $display("test full state shedding done");
  endtask : t_shed_full
  // Transient and core voltage command reset shedding, then re-arm
  task automatic t_shed_reset;
    ltd = 1'b1;
    @(negedge clk);
    ltd = 1'b0;
    `CHK("active_phases", 3'h6, ph)
    repeat (500) @(negedge clk);
    `CHK("active_phases", 3'h6, ph)
    wait_ph(3'h1);
    `CHK("active_phases", 3'h1, ph)
    master.send_vid_core();
    `CHK("active_phases", 3'h6, ph)
    wait_ph(3'h1);
    `CHK("active_phases", 3'h1, ph)
    $display("test shed reset done");
  endtask : t_shed_reset
  // Prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    ready = 1'b1;
    t_reset();
    t_full();
    t_shed_full();
    t_light();
    t_shed_reset();
    stop_test();
  end
  // Watchdog: well beyond the expected run length
  initial begin
    #3_000_000;
    fails++;
    stop_test();
  end
endmodule : power_state_efficiency_control_tb_top
